// File: data_decode_op.sv
// data decoder execution unit: digits or bytes to one-hot result words
// Contract
// [RULE1] top control digit 0 picks digit decode, 1 picks byte decode
// [RULE2] digit mode: each digit sets only its indexed bit of one word
// [RULE3] digit mode converts one to four digits per operation
// [RULE4] byte mode: each byte sets one bit in a sixteen-word block
// [RULE5] byte value is bit index into 256-bit field, single one
// [RULE6] byte mode converts one or two bytes per operation
// [RULE7] digits taken upward from start, wrapping from digit 3 to 0
// [RULE8] two bytes from byte 1 take byte 0 second by wrapping
// [RULE9] n-th digit decode goes to result offset n-1, up to 3
// [RULE10] first byte to offsets 0..15, second byte to 16..31
// [RULE11] program keeps all result words inside one data area
// [RULE12] fault flag set on unsupported control, cleared otherwise
// [RULE13] control 0021 decodes three digits from digit 1
// [RULE14] control 1011 decodes both bytes from byte 1
// [RULE15] low digit is start, next is count-1; bad values write nothing
`timescale 1ns/100ps
`default_nettype none
module data_decode_op
  import decode_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // operands and trigger from sequencer
  input wire logic start,
  input wire logic [decode_pkg::WORD_W-1:0] source_word,
  input wire logic [decode_pkg::WORD_W-1:0] control_word,
  // result word stream
  output logic result_valid,
  output logic [decode_pkg::OFS_W-1:0] result_offset,
  output logic [decode_pkg::WORD_W-1:0] result_word,
  // status
  output logic busy,
  output logic done,
  output logic fault_indicator
);
  import decode_pkg::*;

  // ==========================================
  // control word checking
  function automatic logic ctl_ok(input logic [15:0] c);
    logic [3:0] md;
    logic [3:0] cnt;
    logic [3:0] st;
    md = c[CTL_MODE_LSB +: FIELD_W];
    cnt = c[CTL_COUNT_LSB +: FIELD_W];
    st = c[CTL_START_LSB +: FIELD_W];
    ctl_ok = 1'b0;
    if (c[CTL_ZERO_LSB +: FIELD_W] != 4'h0) begin
      ctl_ok = 1'b0;
    end else if (md == MODE_DIGIT) begin
      ctl_ok = (cnt < 4'(MAX_DIGITS)) && (st < 4'(MAX_DIGITS)); // RULE3
    end else if (md == MODE_BYTE) begin
      ctl_ok = (cnt < 4'(MAX_BYTES)) && (st < 4'(MAX_BYTES)); // RULE6
    end
  endfunction : ctl_ok

  // ==========================================
  // sequencing state
  unit_state_t state_ff, nxt_state;
  logic [15:0] src_ff, nxt_src;
  logic mode_ff, nxt_mode;
  logic [1:0] unit_ff, nxt_unit;
  logic [1:0] left_ff, nxt_left;
  logic [3:0] sub_ff, nxt_sub;
  logic [OFS_W-1:0] ofs_ff, nxt_ofs;
  logic valid_ff, nxt_valid;
  logic [15:0] word_ff, nxt_word;
  logic done_ff, nxt_done;
  logic fault_ff, nxt_fault;
  logic [7:0] cur_index;
  logic [15:0] dec_word;

  // ==========================================
  // digit and byte taps of the latched source
  logic [DIGIT_W-1:0] digit_tap [MAX_DIGITS];
  logic [BYTE_W-1:0] byte_tap [MAX_BYTES];
  for (genvar g = 0; g < MAX_DIGITS; g++) begin : g_digit
    assign digit_tap[g] = src_ff[g*DIGIT_W +: DIGIT_W];
  end
  for (genvar g = 0; g < MAX_BYTES; g++) begin : g_byte
    assign byte_tap[g] = src_ff[g*BYTE_W +: BYTE_W];
  end

  // ==========================================
  // pick current digit or byte of the latched source
  always_comb begin
    cur_index = 8'h00;
    if (mode_ff) begin
      cur_index = byte_tap[unit_ff[0]]; // RULE5 RULE8
    end else begin
      cur_index = {4'h0, digit_tap[unit_ff]}; // RULE7
    end
  end

  // ==========================================
  // one-hot decode of the current digit or byte
  onehot_word u_onehot (
    .bit_index(cur_index),
    .word_sel(sub_ff),
    .byte_mode(mode_ff),
    .word_out(dec_word) // RULE2 RULE4
  );

  // ==========================================
  // next state and stream stepping
  always_comb begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    nxt_mode = mode_ff;
    nxt_unit = unit_ff;
    nxt_left = left_ff;
    nxt_sub = sub_ff;
    nxt_ofs = ofs_ff;
    nxt_valid = 1'b0;
    nxt_word = word_ff;
    nxt_done = 1'b0;
    nxt_fault = fault_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start) begin
          if (ctl_ok(control_word)) begin
            nxt_fault = 1'b0; // RULE12
            nxt_state = ST_WRITE;
            nxt_src = source_word;
            nxt_mode = control_word[CTL_MODE_LSB +: FIELD_W]
              == MODE_BYTE; // RULE1
            nxt_unit = control_word[CTL_START_LSB +: 2]; // RULE15 RULE14
            nxt_left = control_word[CTL_COUNT_LSB +: 2]; // RULE15 RULE13
            nxt_sub = 4'h0;
            nxt_ofs = OFS_RST;
          end else begin
            // refused control word: no words, done at once
            nxt_fault = 1'b1; // RULE12 RULE15
            nxt_done = 1'b1;
          end
        end
      end
      ST_WRITE: begin
        nxt_valid = 1'b1;
        nxt_word = dec_word;
        nxt_ofs = ofs_ff + 5'd1; // RULE9 RULE10
        // byte mode walks sixteen words per byte
        if (mode_ff && sub_ff != 4'(BLOCK_WORDS - 1)) begin
          nxt_sub = sub_ff + 4'd1;
        end else begin
          nxt_sub = 4'h0;
          if (mode_ff) begin
            nxt_unit = {1'b0, ~unit_ff[0]}; // RULE8
          end else begin
            nxt_unit = unit_ff + 2'd1; // RULE7
          end
          if (left_ff == 2'd0) begin
            nxt_state = ST_IDLE;
            nxt_done = 1'b1;
          end else begin
            nxt_left = left_ff - 2'd1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================
  // state registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      src_ff <= RESULT_RST;
      mode_ff <= 1'b0;
      unit_ff <= 2'd0;
      left_ff <= 2'd0;
      sub_ff <= 4'h0;
      ofs_ff <= OFS_RST;
      valid_ff <= 1'b0;
      word_ff <= RESULT_RST;
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      src_ff <= nxt_src;
      mode_ff <= nxt_mode;
      unit_ff <= nxt_unit;
      left_ff <= nxt_left;
      sub_ff <= nxt_sub;
      ofs_ff <= nxt_ofs;
      valid_ff <= nxt_valid;
      word_ff <= nxt_word;
      done_ff <= nxt_done;
      fault_ff <= nxt_fault;
    end
  end

  // ==========================================
  // offset output registered alongside the word
  logic [OFS_W-1:0] out_ofs_ff, nxt_out_ofs;
  logic busy_ff, nxt_busy;
  always_comb begin
    nxt_out_ofs = (state_ff == ST_WRITE) ? ofs_ff : out_ofs_ff;
    nxt_busy = (nxt_state == ST_WRITE);
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_ofs_ff <= OFS_RST;
      busy_ff <= 1'b0;
    end else begin
      out_ofs_ff <= nxt_out_ofs;
      busy_ff <= nxt_busy;
    end
  end

  // ==========================================
  // port drive
  assign result_valid = valid_ff;
  assign result_offset = out_ofs_ff;
  assign result_word = word_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign fault_indicator = fault_ff;
endmodule : data_decode_op
`default_nettype wire

// File: decode_checker_assertions.sv
// checker for the data decoder unit
`timescale 1ns/100ps
`default_nettype none
module decode_checker (
  // clock, reset
  input wire logic mclk,
  input wire logic resetn,
  // operands
  input wire logic start,
  input wire logic [15:0] source_word,
  input wire logic [15:0] control_word,
  // results
  input wire logic result_valid,
  input wire logic [4:0] result_offset,
  input wire logic [15:0] result_word,
  input wire logic busy,
  input wire logic done,
  input wire logic fault_indicator
);
  logic [15:0] s_ff, c_ff;
  logic tk, bad;
  logic [3:0] lim;
  logic [1:0] dg;
  logic [7:0] b;
  assign tk = start && !busy;
  assign lim = control_word[12] ? 4'h1 : 4'h3;
  assign bad = control_word[15:8] != {3'h0, control_word[12], 4'h0}
    || control_word[7:4] > lim || control_word[3:0] > lim;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) {s_ff, c_ff} <= 32'h0000_0000;
    else if (tk) {s_ff, c_ff} <= {source_word, control_word};
  assign dg = c_ff[1:0] + result_offset[1:0];
  assign b = (c_ff[0] ^ result_offset[4]) ? s_ff[15:8] : s_ff[7:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_dig; result_valid && !c_ff[12] |->
    result_word == 16'h0001 << s_ff[4*dg +: 4]; endproperty
  a_dig: assert property (p_dig) else $error("digit word");
  property p_byt; result_valid && c_ff[12] |-> result_word ==
    ((b[7:4] == result_offset[3:0]) ? 16'h0001 << b[3:0] : 16'h0000);
  endproperty
  a_byt: assert property (p_byt) else $error("byte word");
  property p_flt; tk && bad |=> done && fault_indicator && !result_valid;
  endproperty
  a_flt: assert property (p_flt) else $error("fault");
  property p_ok; tk && !bad |=> ##1 !fault_indicator && result_valid
    && result_offset == 5'h00; endproperty
  a_ok: assert property (p_ok) else $error("first word");
  property p_run; result_valid && !done |=> result_valid
    && result_offset == $past(result_offset) + 5'h01; endproperty
  a_run: assert property (p_run) else $error("stream");
  property p_dl; result_valid && done && !c_ff[12] |->
    result_offset == {1'b0, c_ff[7:4]}; endproperty
  a_dl: assert property (p_dl) else $error("digit count");
  property p_bl; result_valid && done && c_ff[12] |->
    result_offset == {c_ff[4], 4'hF}; endproperty
  a_bl: assert property (p_bl) else $error("byte count");
  property p_bsy; tk && !bad |=> busy; endproperty
  a_bsy: assert property (p_bsy) else $error("busy");
endmodule : decode_checker
bind data_decode_op decode_checker u_decode_checker (.mclk, .resetn,
  .start, .source_word, .control_word, .result_valid, .result_offset,
  .result_word, .busy, .done, .fault_indicator);
`default_nettype wire

// File: decode_pkg.sv
// constants for the data decoder execution unit
package decode_pkg;
  localparam int WORD_W = 16;
  localparam int DIGIT_W = 4;
  localparam int BYTE_W = 8;
  // control word fields
  localparam int CTL_START_LSB = 0;
  localparam int CTL_COUNT_LSB = 4;
  localparam int CTL_ZERO_LSB = 8;
  localparam int CTL_MODE_LSB = 12;
  localparam int FIELD_W = 4;
  localparam logic [3:0] MODE_DIGIT = 4'h0;
  localparam logic [3:0] MODE_BYTE = 4'h1;
  // limits
  localparam int MAX_DIGITS = 4;
  localparam int MAX_BYTES = 2;
  localparam int BLOCK_WORDS = 16;
  localparam int MAX_RESULT_WORDS = 32;
  localparam int OFS_W = 5;
  // reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [4:0] OFS_RST = 5'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE} unit_state_t;
endpackage : decode_pkg

// File: onehot_word.sv
// one result word of a one-hot decode: bit value==index, masked by word in byte mode only
`timescale 1ns/100ps
`default_nettype none
module onehot_word (
  // index and word selector
  input wire logic [7:0] bit_index,
  input wire logic [3:0] word_sel,
  input wire logic byte_mode,
  // decoded word
  output logic [15:0] word_out
);
  always_comb begin
    word_out = 16'h0000;
    if (!byte_mode) begin
      word_out[bit_index[3:0]] = 1'b1;
    end else if (bit_index[7:4] == word_sel) begin
      word_out[bit_index[3:0]] = 1'b1;
    end
  end
endmodule : onehot_word
`default_nettype wire

// File: seq_model.sv
// sequencer model: issues operands, stores result stream
`timescale 1ns/100ps
`default_nettype none
module seq_model (
  // clock, reset
  input wire logic mclk,
  input wire logic resetn,
  // bench request
  input wire logic go,
  input wire logic [15:0] src,
  input wire logic [15:0] ctl,
  // unit side
  output logic start,
  output logic [15:0] source_word,
  output logic [15:0] control_word,
  input wire logic result_valid,
  input wire logic [4:0] result_offset,
  input wire logic [15:0] result_word
);
  logic [15:0] mem [32];
  int cnt;
  always @(posedge mclk or negedge resetn)
    if (!resetn) {start, source_word, control_word} <= 33'h0;
    else if (go) {start, source_word, control_word} <= {1'b1, src, ctl};
    // released operands turn to garbage
    else if (start)
      {start, source_word, control_word} <=
        {1'b0, ~source_word, ~control_word};
  always @(posedge mclk)
    if (go) cnt <= 0;
    else if (result_valid) begin
      mem[result_offset] <= result_word;
      cnt <= cnt + 1;
    end
endmodule : seq_model
`default_nettype wire

// File: tb_top.sv
// bench for the data decoder unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [15:0] s, c; logic f; int n;} row_t;
  logic mclk = 1'b0, resetn = 1'b0, go = 1'b0;
  logic [15:0] src = 16'h0000, ctl = 16'h0000;
  logic start, result_valid, busy, done, fault_indicator;
  logic [15:0] source_word, control_word, result_word;
  logic [4:0] result_offset;
  int bad_count = 0, num_checks = 0, cyc = 0;
  row_t rows [12] = '{'{16'h4321, 16'h0000, 1'b0, 1},
    '{16'hFA50, 16'h0021, 1'b0, 3},
    '{16'h0C8F, 16'h0033, 1'b0, 4}, '{16'h9E27, 16'h0012, 1'b0, 2},
    '{16'hA53C, 16'h1011, 1'b0, 32},
    '{16'h00FF, 16'h1000, 1'b0, 16}, '{16'h1234, 16'h2000, 1'b1, 0},
    '{16'h1234, 16'h0100, 1'b1, 0}, '{16'h1234, 16'h1020, 1'b1, 0},
    '{16'h1234, 16'h1002, 1'b1, 0}, '{16'h1234, 16'h0040, 1'b1, 0},
    '{16'h7F80, 16'h1010, 1'b0, 32}};
  data_decode_op u_data_decode_op (.mclk, .resetn, .start, .source_word,
    .control_word, .result_valid, .result_offset, .result_word, .busy,
    .done, .fault_indicator);
  seq_model u_seq_model (.mclk, .resetn, .go, .src, .ctl, .start,
    .source_word, .control_word, .result_valid, .result_offset,
    .result_word);
  always #50 mclk = ~mclk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  always @(posedge mclk) if (++cyc == 5000) begin
    bad_count++;
    wrap_up();
  end
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  function automatic logic [15:0] ew(logic [15:0] s, c, int k);
    logic [1:0] d;
    logic [7:0] b;
    d = c[1:0] + k[1:0];
    b = (c[0] ^ k[4]) ? s[15:8] : s[7:0];
    if (c[12]) return (b[7:4] == k[3:0]) ? 16'h0001 << b[3:0] : 16'h0000;
    return 16'h0001 << s[4*d +: 4];
  endfunction : ew
  task automatic run(logic [15:0] s, c);
    int w = 0;
    @(posedge mclk);
    {src, ctl, go} <= {s, c, 1'b1};
    @(posedge mclk);
    go <= 1'b0;
    do begin
      @(posedge mclk);
      #1 w++;
    end while (done !== 1'b1 && w < 60);
    chk("done", 1'b1, done);
    @(posedge mclk);
    #1;
  endtask : run
  initial begin
    @(posedge mclk);
    #1 chk("reset outs", 4'h0, {busy, done, result_valid, fault_indicator});
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i].s, rows[i].c);
      chk("fault", rows[i].f, fault_indicator);
      chk("words", rows[i].n, u_seq_model.cnt);
      for (int k = 0; k < rows[i].n; k++)
        chk("word", ew(rows[i].s, rows[i].c, k),
          u_seq_model.mem[k]);
      $display("test %0d end", i);
    end
    @(posedge mclk);
    {src, ctl, go} <= {16'h00FF, 16'h1000, 1'b1};
    @(posedge mclk);
    go <= 1'b0;
    repeat (6) @(posedge mclk);
    {ctl, go} <= {16'h0000, 1'b1};
    @(posedge mclk);
    go <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk("refused", 16'h0000, u_seq_model.mem[0]);
    @(posedge mclk);
    resetn <= 1'b0;
    #1 chk("mid reset", 4'h0, {busy, done, result_valid, fault_indicator});
    @(posedge mclk);
    resetn <= 1'b1;
    run(16'hFA50, 16'h0021);
    chk("after reset", 16'h0400, u_seq_model.mem[1]);
    $display("test refuse and reset end");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
